/* File: verilog/cspc_defines.svh */
// Bit positions, reset values and bank indices of the stack and privilege control register.
// Included by the package users; holds definitions only.
`ifndef CSPC_DEFINES_SVH
`define CSPC_DEFINES_SVH

`define CSPC_REG_W 32
`define CSPC_BIT_UNPRIV 0
`define CSPC_BIT_STACK_SEL 1
`define CSPC_BIT_FP_ACTIVE 2
`define CSPC_BIT_FP_OWNER 3
`define CSPC_USED_BITS 4

`define CSPC_RST_UNPRIV 1'b0
`define CSPC_RST_STACK_SEL 1'b0
`define CSPC_RST_FP_ACTIVE 1'b0
`define CSPC_RST_FP_OWNER 1'b0

`define CSPC_NUM_BANKS 2
`define CSPC_BANK_NS 0
`define CSPC_BANK_S 1

`endif

/* File: verilog/cspc_pkg.sv */
// Types shared by the stack and privilege control register and its per-state bank.
// Assumes the defines header is compiled alongside.
package cspc_pkg;

    typedef enum logic [1:0] {
        CSPC_MODE_THREAD = 2'b01,
        CSPC_MODE_HANDLER = 2'b10
    } cspc_mode_type;

    // Exception-return code fields that steer this register
    typedef struct packed {
        logic secure;
        logic to_thread;
        logic process_sp;
        logic no_fp_frame;
    } cspc_exc_code_type;

    // One special-register access: strobe, state of the accessor, and Secure access to the NS copy
    typedef struct packed {
        logic en;
        logic secure;
        logic ns_alias;
    } cspc_sysreg_acc_type;

endpackage

/* File: verilog/cspc_bank.sv */
// One Security-state copy of the banked stack-select and privilege bits.
// Assumes the parent resolves mode and priority into the write enables.
`timescale 1ns/1ps
`include "cspc_defines.svh"

module cspc_bank (
    input wire logic clk,
    input wire logic rst,
    input wire logic stack_sel_we,
    input wire logic stack_sel_wv,
    input wire logic unpriv_we,
    input wire logic unpriv_wv,
    output logic stack_sel_r,
    output logic unpriv_r
);
    import cspc_pkg::*;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack_sel_r <= `CSPC_RST_STACK_SEL;
        end else if (stack_sel_we) begin
            stack_sel_r <= stack_sel_wv;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unpriv_r <= `CSPC_RST_UNPRIV;
        end else if (unpriv_we) begin
            unpriv_r <= unpriv_wv;
        end
    end

endmodule

/* File: verilog/cspc_top.sv */
// Stack and privilege control register of the core, banked per Security state bit by bit.
// Assumes the core pipeline gives one-cycle strobes for special-register reads and writes,
// exception entry and exception return, and checks privilege before issuing a write.
//
// Notes on behaviour
// - Keep a Secure floating-point ownership flag at bit 3; 1 means Secure FP state.
// - Ownership flag has one copy; Non-secure accesses read zero and cannot write it.
// - Keep a shared floating-point-context-active flag at bit 2.
// - Exception entry uses the context-active flag to decide on preserving FP state.
// - Stack-select bit 1 picks main stack (0) or process stack (1).
// - In Handler mode stack-select reads zero and explicit writes are ignored.
// - Exception return updates the stack-select bit automatically.
// - Handler mode always runs on the main stack pointer.
// - Bit 0 sets Thread privilege: 0 privileged, 1 unprivileged.
// - Stack-select and privilege are banked per state; FP flags have one copy.
// - Return rewrites stack-select and FP-active from its exception-return code; entry clears them and the owner flag.
// - After reset Thread mode uses the main stack pointer.
// - Thread moves to process stack by a write of 1 or a suitable return.
// - Every exception except reset runs in Handler mode.
`timescale 1ns/1ps
`include "cspc_defines.svh"

module cspc_top (
    input wire logic clk,
    input wire logic rst,
    input wire cspc_pkg::cspc_sysreg_acc_type wr_acc,
    input wire logic [31:0] wr_data,
    input wire cspc_pkg::cspc_sysreg_acc_type rd_acc,
    input wire logic cur_secure,
    input wire logic fp_instr_exec,
    input wire logic exc_entry,
    input wire logic exc_entry_secure,
    input wire logic exception_return_code,
    input wire cspc_pkg::cspc_exc_code_type exception_return_code_code,
    output logic [31:0] rd_data_r,
    output logic rd_valid_r,
    output logic handler_mode_r,
    output logic sp_is_process_r,
    output logic thread_unpriv_r,
    output logic fp_context_active_r,
    output logic secure_fp_owner_r,
    output logic fp_preserve_r,
    output cspc_pkg::cspc_exc_code_type entry_code_r,
    output logic entry_code_valid_r
);
    import cspc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State

    cspc_mode_type mode_r;
    cspc_mode_type mode_nxt;
    logic fp_active_r;
    logic fp_active_nxt;
    logic fp_owner_r;
    logic fp_owner_nxt;
    logic [`CSPC_NUM_BANKS-1:0] stack_sel_bank;
    logic [`CSPC_NUM_BANKS-1:0] unpriv_bank;
    logic in_handler;
    logic wr_eff_secure;
    logic rd_eff_secure;
    logic wr_bank;
    logic rd_bank;
    logic cur_bank;
    logic [31:0] rd_word;

    assign in_handler = (mode_r == CSPC_MODE_HANDLER);
    // A Secure access to the NS copy behaves as a Non-secure view of the shared bits
    assign wr_eff_secure = wr_acc.secure & ~wr_acc.ns_alias;
    assign rd_eff_secure = rd_acc.secure & ~rd_acc.ns_alias;
    assign wr_bank = wr_eff_secure;
    assign rd_bank = rd_eff_secure;
    assign cur_bank = cur_secure;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode tracking

    always_comb begin
        mode_nxt = mode_r;
        if (exception_return_code) begin
            mode_nxt = exception_return_code_code.to_thread ? CSPC_MODE_THREAD : CSPC_MODE_HANDLER;
        end else if (exc_entry) begin
            mode_nxt = CSPC_MODE_HANDLER;
        end
    end

    // Reset leaves the core in Thread mode, never Handler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= CSPC_MODE_THREAD;
        end else begin
            case (mode_nxt)
                CSPC_MODE_THREAD: begin
                    mode_r <= CSPC_MODE_THREAD;
                end
                CSPC_MODE_HANDLER: begin
                    mode_r <= CSPC_MODE_HANDLER;
                end
                default: begin
                    mode_r <= CSPC_MODE_THREAD;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Banked stack-select and privilege bits

    genvar b;
    generate
        for (b = 0; b < `CSPC_NUM_BANKS; b = b + 1) begin : g_bank
            logic is_wr_bank;
            logic is_entry_bank;
            logic is_ret_bank;
            logic stack_sel_we;
            logic stack_sel_wv;
            logic unpriv_we;

            assign is_wr_bank = wr_acc.en && (wr_bank == 1'(b));
            assign is_entry_bank = exc_entry && (exc_entry_secure == 1'(b));
            assign is_ret_bank = exception_return_code && (exception_return_code_code.secure == 1'(b));

            // Exception events take precedence over a software write in the same cycle
            always_comb begin
                stack_sel_we = 1'b0;
                stack_sel_wv = 1'b0;
                if (is_ret_bank) begin
                    stack_sel_we = 1'b1;
                    stack_sel_wv = exception_return_code_code.to_thread
                        & exception_return_code_code.process_sp;
                end else if (is_entry_bank) begin
                    stack_sel_we = 1'b1;
                    stack_sel_wv = 1'b0;
                end else if (is_wr_bank && !in_handler && !exc_entry && !exception_return_code) begin
                    stack_sel_we = 1'b1;
                    stack_sel_wv = wr_data[`CSPC_BIT_STACK_SEL];
                end
            end

            assign unpriv_we = is_wr_bank && !exc_entry && !exception_return_code;

            cspc_bank u_bank (
                .clk(clk),
                .rst(rst),
                .stack_sel_we(stack_sel_we),
                .stack_sel_wv(stack_sel_wv),
                .unpriv_we(unpriv_we),
                .unpriv_wv(wr_data[`CSPC_BIT_UNPRIV]),
                .stack_sel_r(stack_sel_bank[b]),
                .unpriv_r(unpriv_bank[b])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Shared floating-point flags

    // Priority: exceptions, then FP instruction set (set beats a software clear), then software write
    always_comb begin
        fp_active_nxt = fp_active_r;
        if (wr_acc.en) begin
            fp_active_nxt = wr_data[`CSPC_BIT_FP_ACTIVE];
        end
        if (fp_instr_exec) begin
            fp_active_nxt = 1'b1;
        end
        if (exception_return_code) begin
            fp_active_nxt = ~exception_return_code_code.no_fp_frame;
        end else if (exc_entry) begin
            fp_active_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fp_active_r <= `CSPC_RST_FP_ACTIVE;
        end else begin
            fp_active_r <= fp_active_nxt;
        end
    end

    always_comb begin
        fp_owner_nxt = fp_owner_r;
        if (wr_acc.en && wr_eff_secure) begin
            fp_owner_nxt = wr_data[`CSPC_BIT_FP_OWNER];
        end
        if (fp_instr_exec && cur_secure) begin
            fp_owner_nxt = 1'b1;
        end
        if (exc_entry && !exception_return_code) begin
            fp_owner_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fp_owner_r <= `CSPC_RST_FP_OWNER;
        end else begin
            fp_owner_r <= fp_owner_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read

    always_comb begin
        rd_word = '0;
        rd_word[`CSPC_BIT_UNPRIV] = unpriv_bank[rd_bank];
        rd_word[`CSPC_BIT_STACK_SEL] = stack_sel_bank[rd_bank] & ~in_handler;
        rd_word[`CSPC_BIT_FP_ACTIVE] = fp_active_r;
        rd_word[`CSPC_BIT_FP_OWNER] = fp_owner_r & rd_eff_secure;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_r <= 32'h0000_0000;
        end else if (rd_acc.en) begin
            rd_data_r <= rd_word;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_acc.en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Exception entry code and FP preservation

    // A return in the same cycle wins, so no entry is reported then
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            entry_code_valid_r <= 1'b0;
        end else begin
            entry_code_valid_r <= exc_entry && !exception_return_code;
        end
    end

    // Pulse tells the stacking logic whether the FP registers go on the frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fp_preserve_r <= 1'b0;
        end else begin
            fp_preserve_r <= exc_entry && !exception_return_code && fp_active_r;
        end
    end

    // Code describes the context being left so the later return can restore it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            entry_code_r <= '0;
        end else if (exc_entry && !exception_return_code) begin
            entry_code_r.secure <= cur_secure;
            entry_code_r.to_thread <= ~in_handler;
            entry_code_r.process_sp <= stack_sel_bank[cur_bank] & ~in_handler;
            entry_code_r.no_fp_frame <= ~fp_active_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Execution-state outputs; they follow the state with one cycle of lag.
    // The lag is why software needs a sync barrier after changing the stack.

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            handler_mode_r <= 1'b0;
        end else begin
            handler_mode_r <= in_handler;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sp_is_process_r <= 1'b0;
        end else begin
            sp_is_process_r <= stack_sel_bank[cur_bank] & ~in_handler;
        end
    end

    // Privilege level only applies in Thread mode; handlers always run privileged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            thread_unpriv_r <= 1'b0;
        end else begin
            thread_unpriv_r <= unpriv_bank[cur_bank] & ~in_handler;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fp_context_active_r <= 1'b0;
        end else begin
            fp_context_active_r <= fp_active_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            secure_fp_owner_r <= 1'b0;
        end else begin
            secure_fp_owner_r <= fp_owner_r;
        end
    end

endmodule

/* File: tb/cspc_checker.sv */
// Concurrent checks on the stack and privilege control register ports.
// Assumes it is bound to cspc_top; status outputs lag internal state by one edge.
`timescale 1ns/1ps
module cspc_checker (
    input wire logic clk,
    input wire logic rst,
    input wire cspc_pkg::cspc_sysreg_acc_type rd_acc,
    input wire logic cur_secure,
    input wire logic fp_instr_exec,
    input wire logic exc_entry,
    input wire logic exception_return_code,
    input wire cspc_pkg::cspc_exc_code_type exception_return_code_code,
    input wire logic [31:0] rd_data_r,
    input wire logic rd_valid_r,
    input wire logic handler_mode_r,
    input wire logic sp_is_process_r,
    input wire logic fp_context_active_r,
    input wire logic secure_fp_owner_r,
    input wire logic fp_preserve_r,
    input wire cspc_pkg::cspc_exc_code_type entry_code_r,
    input wire logic entry_code_valid_r
);
    import cspc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_upper_zero: assert property (rd_valid_r |-> rd_data_r[31:4] == 28'h0)
        else $error("upper read bits not zero");
    chk_ns_owner_raz: assert property (
        rd_acc.en && !(rd_acc.secure && !rd_acc.ns_alias) |=> rd_valid_r && !rd_data_r[3])
        else $error("owner flag visible to non-secure read");
    // A return taken on the previous edge may already have left Handler mode
    chk_handler_sel_zero: assert property (
        rd_acc.en && handler_mode_r && !$past(exception_return_code) |=> !rd_data_r[1])
        else $error("stack select read as one in handler mode");
    chk_handler_msp: assert property (handler_mode_r |-> !sp_is_process_r)
        else $error("process stack active in handler mode");
    chk_preserve_code: assert property (
        exc_entry && !exception_return_code |=> entry_code_valid_r
        && fp_preserve_r == !entry_code_r.no_fp_frame)
        else $error("preserve pulse disagrees with entry code");
    chk_entry_handler: assert property (exc_entry && !exception_return_code |-> ##2 handler_mode_r)
        else $error("entry did not reach handler mode");
    chk_entry_fp_clear: assert property (
        exc_entry && !exception_return_code |-> ##2 !fp_context_active_r && !secure_fp_owner_r)
        else $error("entry left floating point flags set");
    chk_return_stack: assert property (
        exception_return_code && exception_return_code_code.to_thread && cur_secure == exception_return_code_code.secure
        ##1 $stable(cur_secure) |=> !handler_mode_r
        && sp_is_process_r == $past(exception_return_code_code.process_sp, 2))
        else $error("return did not restore thread stack");
    chk_fp_set: assert property (
        fp_instr_exec && !exc_entry && !exception_return_code |-> ##2 fp_context_active_r)
        else $error("context flag not set by fp instruction");
endmodule

bind cspc_top cspc_checker u_cspc_checker (.clk, .rst, .rd_acc, .cur_secure, .fp_instr_exec,
    .exc_entry, .exception_return_code, .exception_return_code_code, .rd_data_r, .rd_valid_r, .handler_mode_r,
    .sp_is_process_r, .fp_context_active_r, .secure_fp_owner_r, .fp_preserve_r,
    .entry_code_r, .entry_code_valid_r);

/* File: tb/cspc_sw_model.sv */
// Software side: register accesses and exception events issued to the register.
// Assumes requests change at the falling edge and last one cycle.
`timescale 1ns/1ps
module cspc_sw_model (
    input wire logic clk,
    output cspc_pkg::cspc_sysreg_acc_type wr_acc,
    output logic [31:0] wr_data,
    output cspc_pkg::cspc_sysreg_acc_type rd_acc,
    output logic cur_secure,
    output logic fp_instr_exec,
    output logic exc_entry,
    output logic exc_entry_secure,
    output logic exception_return_code,
    output cspc_pkg::cspc_exc_code_type exception_return_code_code
);
    import cspc_pkg::*;
    initial begin
        wr_acc = '0;
        rd_acc = '0;
        wr_data = 32'h0;
        cur_secure = 1'b1;
        {fp_instr_exec, exc_entry, exception_return_code} = 3'h0;
        exc_entry_secure = 1'b1;
        exception_return_code_code = '0;
    end
    task automatic wr(input logic s, input logic a, input logic [31:0] d);
        @(negedge clk);
        wr_acc = '{1'b1, s, a};
        wr_data = d;
        @(negedge clk);
        wr_acc = '0;
        wr_data = ~d;
        // Barrier: nothing issued until the new stack choice has settled
        @(negedge clk);
    endtask
    task automatic rd(input logic s, input logic a);
        @(negedge clk);
        rd_acc = '{1'b1, s, a};
        @(negedge clk);
        rd_acc = '0;
    endtask
    // Moves execution and the target of later exceptions to one Security state
    task automatic sec(input logic s);
        @(negedge clk);
        {cur_secure, exc_entry_secure} = {s, s};
    endtask
    task automatic ev(input logic [2:0] k, input cspc_exc_code_type c);
        @(negedge clk);
        {fp_instr_exec, exc_entry, exception_return_code} = k;
        exception_return_code_code = c;
        @(negedge clk);
        {fp_instr_exec, exc_entry, exception_return_code} = 3'h0;
        exception_return_code_code = ~c;
    endtask
endmodule

/* File: tb/core_stack_privilege_control_test.sv */
// Self-checking bench for the stack and privilege control register.
// Assumes cspc_top, its package and the software model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module core_stack_privilege_control_test;
    import cspc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    int errors = 0;
    int cmp_count = 0;
    logic [31:0] rnd = 32'h9621E8C2;
    logic [31:0] rd_q[$];
    logic [4:0] en_q[$];
    logic [31:0] e32;
    logic [4:0] e5;
    cspc_sysreg_acc_type wr_acc, rd_acc;
    cspc_exc_code_type ret_code, entry_code_r;
    logic [31:0] wr_data, rd_data_r;
    logic cur_secure, fp_exec, exc_entry, entry_sec, exception_return_code, rd_valid_r, handler_mode_r;
    logic sp_is_process_r, thread_unpriv_r, fp_active_r, fp_owner_r, fp_preserve_r, entry_valid_r;
    always #10 clk = ~clk;
    cspc_sw_model u_cspc_sw_model (.clk(clk), .wr_acc(wr_acc), .wr_data(wr_data),
        .rd_acc(rd_acc), .cur_secure(cur_secure), .fp_instr_exec(fp_exec),
        .exc_entry(exc_entry), .exc_entry_secure(entry_sec), .exception_return_code(exception_return_code),
        .exception_return_code_code(ret_code));
    cspc_top u_cspc_top (.clk(clk), .rst(rst), .wr_acc(wr_acc), .wr_data(wr_data),
        .rd_acc(rd_acc), .cur_secure(cur_secure), .fp_instr_exec(fp_exec),
        .exc_entry(exc_entry), .exc_entry_secure(entry_sec), .exception_return_code(exception_return_code),
        .exception_return_code_code(ret_code), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .handler_mode_r(handler_mode_r), .sp_is_process_r(sp_is_process_r),
        .thread_unpriv_r(thread_unpriv_r), .fp_context_active_r(fp_active_r),
        .secure_fp_owner_r(fp_owner_r), .fp_preserve_r(fp_preserve_r),
        .entry_code_r(entry_code_r), .entry_code_valid_r(entry_valid_r));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic close_out();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rdx(input logic s, input logic a, input logic [31:0] e);
        rd_q.push_back(e);
        u_cspc_sw_model.rd(s, a);
    endtask
    // Oldest note is matched against each result as it appears
    always @(negedge clk) begin
        if (rd_valid_r === 1'b1) begin
            e32 = rd_q.size() > 0 ? rd_q.pop_front() : 32'hX;
            `CHK("rd_data_r", e32, rd_data_r)
        end
        if (entry_valid_r === 1'b1) begin
            e5 = en_q.size() > 0 ? en_q.pop_front() : 5'hX;
            `CHK("entry_code_r", e5, {fp_preserve_r, entry_code_r})
        end
    end
    initial begin
        #40000;
        errors++;
        close_out();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        rdx(1'b1, 1'b0, 32'h0);
        rdx(1'b0, 1'b0, 32'h0);
        rnd = lfsr(rnd);
        u_cspc_sw_model.wr(1'b1, 1'b0, {rnd[31:4], 4'hF});
        rdx(1'b1, 1'b0, 32'hF);
        rdx(1'b1, 1'b1, 32'h4);
        `CHK("sp_is_process_r", 1'b1, sp_is_process_r)
        `CHK("thread_unpriv_r", 1'b1, thread_unpriv_r)
        `CHK("fp_owner_r", 1'b1, fp_owner_r)
        rnd = lfsr(rnd);
        u_cspc_sw_model.wr(1'b0, 1'b0, {rnd[31:4], 4'hB});
        rdx(1'b1, 1'b0, 32'hB);
        rdx(1'b0, 1'b0, 32'h3);
        u_cspc_sw_model.ev(3'h4, 4'h0);
        en_q.push_back(5'h1E);
        u_cspc_sw_model.ev(3'h2, 4'h0);
        @(negedge clk);
        `CHK("handler_mode_r", 1'b1, handler_mode_r)
        `CHK("sp_is_process_r", 1'b0, sp_is_process_r)
        rdx(1'b1, 1'b0, 32'h1);
        u_cspc_sw_model.wr(1'b1, 1'b0, {rnd[31:4], 4'h2});
        rdx(1'b1, 1'b0, 32'h0);
        rdx(1'b0, 1'b0, 32'h1);
        u_cspc_sw_model.ev(3'h1, 4'hE);
        @(negedge clk);
        rdx(1'b1, 1'b0, 32'h6);
        `CHK("handler_mode_r", 1'b0, handler_mode_r)
        `CHK("sp_is_process_r", 1'b1, sp_is_process_r)
        `CHK("thread_unpriv_r", 1'b0, thread_unpriv_r)
        `CHK("fp_owner_r", 1'b0, fp_owner_r)
        u_cspc_sw_model.sec(1'b0);
        en_q.push_back(5'h16);
        u_cspc_sw_model.ev(3'h2, 4'h0);
        u_cspc_sw_model.ev(3'h4, 4'h0);
        rdx(1'b1, 1'b0, 32'h4);
        repeat (3) @(negedge clk);
        close_out();
    end
endmodule
